/* bench/eip_partner.sv */
// Partner model: external interrupt sources and the two accepting CPU cores.
// Assumes the bench commands pin levels and enables acceptance per core.
`timescale 1ns/10ps

module eip_partner (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] pin_set_i,
  input  wire logic [1:0] accept_en_i,
  input  wire logic [1:0] accept_dly_i,
  input  wire logic [1:0] cpu_req_i,
  output logic      [7:0] irq_pin_o,
  output logic      [1:0] cpu_accept_o
);
  logic [1:0][1:0] cnt_q;

  // Sources hold their pins at the commanded levels
  assign irq_pin_o = pin_set_i;

  ////////////////////////////////////////////////////////////////////////
  // Each core accepts a standing request once, after a set delay
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_accept_o <= 2'h0;
      cnt_q        <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        cpu_accept_o[c] <= 1'b0;
        if (cpu_req_i[c] && accept_en_i[c] && !cpu_accept_o[c]) begin
          if (cnt_q[c] == accept_dly_i) begin
            cpu_accept_o[c] <= 1'b1; // Accept clears a level source
            cnt_q[c]        <= 2'h0;
          end else begin
            cnt_q[c] <= cnt_q[c] + 2'h1;
          end
        end
      end
    end
  end
endmodule

/* bench/test_eip_irq_front.sv */
// Self-checking bench for the pin front end.
// Assumes the partner model on the pin and accept side, seed fixed.
`timescale 1ns/10ps

module test_eip_irq_front;
  import eip_pkg::*;
  logic        clk_i = 0;
  logic        rstn_i = 0;
  logic [5:0]  avs_address_i = 6'h00;
  logic        avs_read_i = 0;
  logic        avs_write_i = 0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [7:0]  pin_set = 8'hFF;
  logic [7:0]  irq_pin;
  logic [1:0]  acc_en = 2'h0;
  logic [1:0]  acc_dly = 2'h0;
  logic [1:0]  cpu_accept;
  logic [1:0]  cpu_req;
  logic [5:0]  cpu_pin;
  logic [7:0]  cpu_level;
  logic [1:0]  enc;
  logic [3:0]  pr [8];
  logic [7:0]  w;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          a;
  int          b;

  // Clock of 40 ns
  always #20 clk_i = ~clk_i;

  eip_irq_front #(.NCPU(2)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_pin_i(irq_pin), .cpu_accept_i(cpu_accept), .cpu_req_o(cpu_req), .cpu_pin_o(cpu_pin),
    .cpu_level_o(cpu_level), .encoded_level_request_o(enc));

  eip_partner u_partner (.clk_i(clk_i), .rstn_i(rstn_i), .pin_set_i(pin_set), .accept_en_i(acc_en),
    .accept_dly_i(acc_dly), .cpu_req_i(cpu_req), .irq_pin_o(irq_pin), .cpu_accept_o(cpu_accept));

  ////////////////////////////////////////////////////////////////////////
  // Comparison, bus cycles and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Holds the request until waitrequest is seen low; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [5:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i   <= ad;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0);
    chk(q, exp);
  endtask

  task automatic tally_and_finish;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Winner: highest priority among flagged pins, lower pin on a tie
  function automatic logic [7:0] winner(input logic [7:0] f);
    logic [7:0] r;
    r = 8'h00;
    for (int p = 0; p < 8; p++) begin
      if (f[p] && pr[p] > r[3:0]) r = {1'b1, p[2:0], pr[p]};
    end
    return r;
  endfunction

  // Watchdog far beyond the expected run
  initial begin
    #(40 * 5000);
    n_mismatch++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(55235));
    tick(20);
    rstn_i <= 1'b1;
    rd(EIP_OFS_MODE, 32'h0);
    rd(EIP_OFS_SENSE, 32'h0);
    rd(EIP_OFS_PRIO, 32'h0);
    rd(EIP_OFS_SRC, 32'h0);
    rd(EIP_OFS_MSK1, 32'hFF000000);
    rd(6'h20, 32'h0);
    // Mask set ignores zeros, clear unmasks only ones
    bus(1'b1, EIP_OFS_MSK0, 32'h0);
    rd(EIP_OFS_MSK0, 32'hFF000000);
    w = 8'($urandom);
    bus(1'b1, EIP_OFS_MCLR0, {w, 24'h0});
    rd(EIP_OFS_MSK0, {~w, 24'h0});
    rd(EIP_OFS_MCLR0, 32'h0);
    bus(1'b1, EIP_OFS_MSK0, 32'h80000000);
    rd(EIP_OFS_MSK0, {~w | 8'h80, 24'h0});
    bus(1'b1, EIP_OFS_MCLR0, 32'hFF000000);
    rd(EIP_OFS_MSK1, 32'hFF000000);
    // Encoded group: priorities and edges have no effect
    // Pin 0 stays without priority here, so no stale request reaches the level tests
    a = 1 + $urandom % 7;
    b = 1 + (a + $urandom % 6) % 7;
    for (int p = 0; p < 8; p++) pr[p] = 4'h0;
    pr[a] = 4'h1 + 4'($urandom % 15);
    pr[b] = 4'h1 + 4'($urandom % 15);
    bus(1'b1, EIP_OFS_PRIO, {pr[0], pr[1], pr[2], pr[3], pr[4], pr[5], pr[6], pr[7]});
    bus(1'b1, EIP_OFS_MSK0, 32'hFF000000);
    pin_set <= 8'hF5;
    tick(4);
    chk(enc, 2'h1);
    chk(cpu_req, 2'h0);
    rd(EIP_OFS_SRC, 32'h0);
    bus(1'b1, EIP_OFS_MODE, 32'h00C00000);
    tick(1);
    chk(enc, 2'h0);
    bus(1'b1, EIP_OFS_MCLR0, 32'hFF000000);
    pin_set <= 8'hFF;
    tick(3);
    // All pins fall; only two carry a priority
    pin_set <= 8'h00;
    tick(3);
    w = winner(8'hFF);
    chk({cpu_req, cpu_pin[2:0], cpu_level[3:0]}, {2'b01, w[6:0]});
    rd(EIP_OFS_SRC, 32'hFF000000);
    acc_dly <= 2'($urandom);
    acc_en  <= 2'h1;
    tick(12);
    chk(cpu_req, 2'h0);
    acc_en <= 2'h0;
    // Edge clear needs a read of 1 before the zero write
    rd(EIP_OFS_SRC, 32'hFF000000);
    bus(1'b1, EIP_OFS_SRC, 32'h7F000000);
    rd(EIP_OFS_SRC, 32'h7F000000);
    pin_set <= 8'h01;
    tick(2);
    pin_set <= 8'h00;
    tick(3);
    bus(1'b1, EIP_OFS_SRC, 32'h0);
    rd(EIP_OFS_SRC, 32'h80000000);
    bus(1'b1, EIP_OFS_SRC, 32'h0);
    rd(EIP_OFS_SRC, 32'h0);
    // Sense switches on pin 0, held low
    pin_set <= 8'h01;
    tick(2);
    pin_set <= 8'h00;
    tick(3);
    bus(1'b1, EIP_OFS_SENSE, 32'h40000000);
    rd(EIP_OFS_SRC, 32'h80000000);
    bus(1'b1, EIP_OFS_SRC, 32'h80000000);
    rd(EIP_OFS_SRC, 32'h80000000);
    bus(1'b1, EIP_OFS_SENSE, 32'hC0000000);
    rd(EIP_OFS_SRC, 32'h0);
    bus(1'b1, EIP_OFS_SENSE, 32'h80000000);
    rd(EIP_OFS_SRC, 32'h80000000);
    bus(1'b1, EIP_OFS_SRC, 32'h0);
    rd(EIP_OFS_SRC, 32'h80000000);
    bus(1'b1, EIP_OFS_SENSE, 32'h0);
    rd(EIP_OFS_SRC, 32'h0);
    // Level request presented and then accepted
    for (int p = 0; p < 8; p++) pr[p] = 4'h0;
    pr[0] = 4'hF;
    bus(1'b1, EIP_OFS_PRIO, 32'hF0000000);
    bus(1'b1, EIP_OFS_SENSE, 32'h80000000);
    tick(3);
    chk({cpu_req, cpu_pin[2:0], cpu_level[3:0]}, {2'b01, 3'h0, 4'hF});
    acc_en <= 2'h1;
    tick(8);
    rd(EIP_OFS_SRC, 32'h0);
    chk(cpu_req, 2'h0);
    // Both cores present one level pin unmasked in both copies
    acc_en <= 2'h0;
    bus(1'b1, EIP_OFS_MCLR1, 32'h40000000);
    rd(EIP_OFS_MSK1, 32'hBF000000);
    bus(1'b1, EIP_OFS_PRIO, 32'hF7000000);
    bus(1'b1, EIP_OFS_SENSE, 32'hA0000000);
    tick(3);
    chk({cpu_req, cpu_pin, cpu_level}, {2'b11, 3'h1, 3'h1, 8'h77});
    tally_and_finish();
  end
endmodule

/* include/eip_pkg.sv */
// Package for the external interrupt pin front end: register offsets,
// field positions, reset values and the bus phase states.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package eip_pkg;

  // Register byte offsets
  localparam logic [5:0] EIP_OFS_MODE  = 6'h00;
  localparam logic [5:0] EIP_OFS_SENSE = 6'h04;
  localparam logic [5:0] EIP_OFS_PRIO  = 6'h08;
  localparam logic [5:0] EIP_OFS_SRC   = 6'h0C;
  localparam logic [5:0] EIP_OFS_MSK0  = 6'h10;
  localparam logic [5:0] EIP_OFS_MSK1  = 6'h14;
  localparam logic [5:0] EIP_OFS_MCLR0 = 6'h18;
  localparam logic [5:0] EIP_OFS_MCLR1 = 6'h1C;

  // Field positions
  localparam int EIP_MODE_LOW_BIT  = 23;
  localparam int EIP_MODE_HIGH_BIT = 22;
  localparam int EIP_SENSE_TOP     = 31;
  localparam int EIP_PRIO_TOP      = 31;
  localparam int EIP_FLAG_TOP      = 31;

  // Reset values
  localparam logic [1:0] EIP_MODE_RST  = 2'h0;
  localparam logic [1:0] EIP_SENSE_RST = 2'h0;
  localparam logic [3:0] EIP_PRIO_RST  = 4'h0;
  localparam logic [7:0] EIP_MASK_RST  = 8'hFF;

  // Sense encodings
  localparam logic [1:0] EIP_SENSE_FALL = 2'h0;
  localparam logic [1:0] EIP_SENSE_RISE = 2'h1;
  localparam logic [1:0] EIP_SENSE_LOW  = 2'h2;
  localparam logic [1:0] EIP_SENSE_HIGH = 2'h3;

  // Encoded group idle pattern (all pins high)
  localparam logic [3:0] EIP_ENC_IDLE = 4'hF;

  // Bus phase, one-hot; bit 0 doubles as waitrequest
  typedef enum logic [1:0] {
    EIP_IDLE = 2'b01,
    EIP_ACK  = 2'b10
  } eip_phase_t;

endpackage

/* verilog/eip_irq_front.sv */
// External interrupt pin front end: sense, priority, per-CPU masks, source
// register and presentation of the winning pin request to two CPU cores.
// Assumes pins synchronous to clk_i and an Avalon-MM master with waitrequest.
//
// Contract
// R01: Group mode bit: 0 encoded, 1 independent
// R02: Mode 0 to 1 clears held encoded request
// R03: Software masks pins of encoded groups
// R04: Sense selections act only in independent mode
// R05: Sense fields: pin0 at 31:30, reset 00
// R06: 00 fall, 01 rise, 10 low, 11 high
// R07: Edge to level clears edge request
// R08: Level to edge clears held request
// R09: Same-kind sense switch keeps request
// R10: Priority fields: pin0 at 31:28, reset 0
// R11: Priority 1..15 enables, 0 masks
// R12: Priorities apply only in independent mode
// R13: Source bits 31:24, unaffected by masks
// R14: Edge source reads 1 after detection
// R15: Edge clear: write 0 after reading 1
// R16: Level source: asserted and not accepted
// R17: Source meaningless for encoded groups
// R18: Mask bits 31:24, reset 1, 1 masks
// R19: Mask write 1 sets, 0 ignored
// R20: Only mask-clear write 1 unmasks
// R21: Mask-clear write-only, reads undefined
// R22: Software reads mask back after change
// R23: Two independent mask copies
// R24: Present highest priority request until accepted
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/10ps

module eip_irq_front
  import eip_pkg::*;
#(
  parameter int NCPU = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [5:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  input  wire logic [7:0]       irq_pin_i,
  input  wire logic [NCPU-1:0]  cpu_accept_i,
  output logic      [NCPU-1:0]  cpu_req_o,
  output logic      [NCPU*3-1:0] cpu_pin_o,
  output logic      [NCPU*4-1:0] cpu_level_o,
  output logic      [1:0]       encoded_level_request_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    eip_phase_t                phase;
    logic [31:0]               rdata;
    logic [1:0]                mode;     // bit0 low group, bit1 high group
    logic [7:0][1:0]           sense;
    logic [7:0][3:0]           prio;
    logic [7:0]                edge_f;
    logic [7:0]                rd1;
    logic [7:0]                acc;
    logic [7:0]                prev;
    logic [NCPU-1:0][7:0]      mask;
    logic [1:0]                enc_held;
    logic [NCPU-1:0]           req;
    logic [NCPU-1:0][2:0]      req_pin;
    logic [NCPU-1:0][3:0]      req_lvl;
  } eip_state_t;

  eip_state_t q;
  eip_state_t d;
  logic [7:0] lvl_w;
  logic [7:0] edg_w;
  logic [7:0] src_w;
  logic       wr_go;
  logic       rd_go;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Highest priority pick; lower pin wins a tie
  function automatic logic [7:0] pick(input logic [7:0] elig, input logic [7:0][3:0] pr);
    logic [3:0] best;
    logic [2:0] idx;
    logic       hit;
    best = 4'h0;
    idx  = 3'h0;
    hit  = 1'b0;
    for (int p = 0; p < 8; p++) begin
      if (elig[p] && pr[p] > best) begin
        best = pr[p];
        idx  = 3'(p);
        hit  = 1'b1;
      end
    end
    pick = {hit, idx, best};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [31:0] bm;
    logic [31:0] wd;
    logic [31:0] rv;
    logic [1:0]  ns;
    logic [7:0]  elig;
    logic [7:0]  pk;
    bm   = lane_mask(avs_byteenable_i);
    wd   = avs_writedata_i;
    rv   = 32'h0000_0000;
    ns   = 2'h0;
    elig = 8'h00;
    pk   = 8'h00;
    d    = q;
    wr_go = avs_write_i && (q.phase == EIP_ACK);
    rd_go = avs_read_i && (q.phase == EIP_ACK);

    // Per-pin sensing, only for independent groups
    for (int p = 0; p < 8; p++) begin
      lvl_w[p] = q.mode[p/4] && q.sense[p][1] && (irq_pin_i[p] == q.sense[p][0]);       // [R04] [R06]
      edg_w[p] = q.mode[p/4] && !q.sense[p][1] &&
                 (q.sense[p][0] ? (!q.prev[p] && irq_pin_i[p]) : (q.prev[p] && !irq_pin_i[p])); // [R06]
      src_w[p] = q.sense[p][1] ? (lvl_w[p] && !q.acc[p]) : q.edge_f[p];                 // [R14] [R16] [R17]
    end
    d.prev = irq_pin_i;

    // Register read mux; reserved bits read 0
    case (avs_address_i)
      EIP_OFS_MODE: begin
        rv[EIP_MODE_LOW_BIT]  = q.mode[0];
        rv[EIP_MODE_HIGH_BIT] = q.mode[1];
      end
      EIP_OFS_SENSE: begin
        for (int p = 0; p < 8; p++) begin
          rv[EIP_SENSE_TOP-2*p -: 2] = q.sense[p];                                      // [R05]
        end
      end
      EIP_OFS_PRIO: begin
        for (int p = 0; p < 8; p++) begin
          rv[EIP_PRIO_TOP-4*p -: 4] = q.prio[p];                                        // [R10]
        end
      end
      EIP_OFS_SRC: begin
        for (int p = 0; p < 8; p++) begin
          rv[EIP_FLAG_TOP-p] = src_w[p];                                                // [R13]
        end
      end
      EIP_OFS_MSK0: begin
        for (int p = 0; p < 8; p++) begin
          rv[EIP_FLAG_TOP-p] = q.mask[0][p];                                            // [R18]
        end
      end
      EIP_OFS_MSK1: begin
        for (int p = 0; p < 8; p++) begin
          rv[EIP_FLAG_TOP-p] = q.mask[1][p];
        end
      end
      default: begin
        rv = 32'h0000_0000;                                                             // [R21]
      end
    endcase

    // Bus phase: one wait cycle, then answer
    case (q.phase)
      EIP_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          d.phase = EIP_ACK;
          if (avs_read_i) begin
            d.rdata = rv;
          end
        end
      end
      EIP_ACK: begin
        d.phase = EIP_IDLE;
      end
      default: begin
        d.phase = EIP_IDLE;
      end
    endcase

    // Encoded groups latch a request once pins leave the idle pattern; only a mode change to independent clears it
    for (int g = 0; g < 2; g++) begin
      if (!q.mode[g] && irq_pin_i[4*g +: 4] != EIP_ENC_IDLE) begin
        d.enc_held[g] = 1'b1;                                                           // [R01]
      end
    end

    // Accepted marks fall once the source condition is gone
    for (int p = 0; p < 8; p++) begin
      if (q.sense[p][1] ? !lvl_w[p] : !q.edge_f[p]) begin
        d.acc[p] = 1'b0;
      end
    end

    // Read of the source register arms the write-0 clear
    if (rd_go && avs_address_i == EIP_OFS_SRC) begin
      d.rd1 = q.rd1 | src_w;
    end

    // Register writes
    if (wr_go) begin
      case (avs_address_i)
        EIP_OFS_MODE: begin
          if (avs_byteenable_i[2]) begin
            ns = {wd[EIP_MODE_HIGH_BIT], wd[EIP_MODE_LOW_BIT]};
            for (int g = 0; g < 2; g++) begin
              if (!q.mode[g] && ns[g]) begin
                d.enc_held[g] = 1'b0;                                                   // [R02]
              end
            end
            d.mode = ns;                                                                // [R01]
          end
        end
        EIP_OFS_SENSE: begin
          for (int p = 0; p < 8; p++) begin
            if (bm[EIP_SENSE_TOP-2*p]) begin
              ns = wd[EIP_SENSE_TOP-2*p -: 2];
              if (!q.sense[p][1] && ns[1]) begin
                d.edge_f[p] = 1'b0;                                                     // [R07]
              end
              if (q.sense[p][1] && !ns[1]) begin
                d.acc[p]    = 1'b0;                                                     // [R08]
                d.edge_f[p] = 1'b0;
              end
              d.sense[p] = ns;                                                          // [R09]
            end
          end
        end
        EIP_OFS_PRIO: begin
          for (int p = 0; p < 8; p++) begin
            if (bm[EIP_PRIO_TOP-4*p]) begin
              d.prio[p] = wd[EIP_PRIO_TOP-4*p -: 4];
            end
          end
        end
        EIP_OFS_SRC: begin
          if (avs_byteenable_i[3]) begin
            for (int p = 0; p < 8; p++) begin
              if (!wd[EIP_FLAG_TOP-p] && q.rd1[p] && !q.sense[p][1]) begin
                d.edge_f[p] = 1'b0;                                                     // [R15]
              end
            end
            d.rd1 = 8'h00;
          end
        end
        EIP_OFS_MSK0, EIP_OFS_MSK1: begin
          if (avs_byteenable_i[3]) begin
            for (int p = 0; p < 8; p++) begin
              if (wd[EIP_FLAG_TOP-p]) begin
                d.mask[avs_address_i[2]][p] = 1'b1;                                     // [R19] [R23]
              end
            end
          end
        end
        EIP_OFS_MCLR0, EIP_OFS_MCLR1: begin
          if (avs_byteenable_i[3]) begin
            for (int p = 0; p < 8; p++) begin
              if (wd[EIP_FLAG_TOP-p]) begin
                d.mask[avs_address_i[2]][p] = 1'b0;                                     // [R20] [R21]
              end
            end
          end
        end
        default: begin
          d.mode = d.mode;
        end
      endcase
    end

    // New edges win over a clear in the same cycle
    d.edge_f = d.edge_f | edg_w;                                                        // [R14]

    // Per-CPU presentation, held until that CPU accepts
    for (int c = 0; c < NCPU; c++) begin
      if (q.req[c]) begin
        if (cpu_accept_i[c]) begin
          d.req[c]            = 1'b0;                                                   // [R24]
          d.acc[q.req_pin[c]] = 1'b1;
        end
      end else begin
        for (int p = 0; p < 8; p++) begin
          elig[p] = src_w[p] && !q.acc[p] && !q.mask[c][p] && q.mode[p/4];              // [R12] [R18]
        end
        pk = pick(elig, q.prio);                                                        // [R11] [R24]
        d.req[c]     = pk[7];
        d.req_pin[c] = pk[6:4];
        d.req_lvl[c] = pk[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q.phase    <= EIP_IDLE;
      q.rdata    <= 32'h0000_0000;
      q.mode     <= EIP_MODE_RST;
      q.sense    <= {8{EIP_SENSE_RST}};
      q.prio     <= {8{EIP_PRIO_RST}};
      q.edge_f   <= 8'h00;
      q.rd1      <= 8'h00;
      q.acc      <= 8'h00;
      q.prev     <= 8'h00;
      q.mask     <= {NCPU{EIP_MASK_RST}};
      q.enc_held <= 2'h0;
      q.req      <= '0;
      q.req_pin  <= '0;
      q.req_lvl  <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata_o          = q.rdata;
  assign avs_waitrequest_o       = q.phase[0];
  assign cpu_req_o               = q.req;
  assign cpu_pin_o               = q.req_pin;
  assign cpu_level_o             = q.req_lvl;
  assign encoded_level_request_o = q.enc_held;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  bus_answer_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (q.phase == EIP_IDLE && (avs_read_i || avs_write_i)) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle after request");
  mode_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R02]
    (wr_go && avs_address_i == EIP_OFS_MODE && avs_byteenable_i[2] && !q.mode[0] &&
     avs_writedata_i[EIP_MODE_LOW_BIT]) |=> (q.mode[0] && !q.enc_held[0]))
    else $error("encoded request kept after mode change to independent");
  edge_level_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R07]
    (wr_go && avs_address_i == EIP_OFS_SENSE && avs_byteenable_i[3] && !q.sense[0][1] &&
     avs_writedata_i[31] && !edg_w[0]) |=> !q.edge_f[0])
    else $error("edge request kept after switch to level sense");
  edge_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R14]
    edg_w[0] |=> (q.edge_f[0] && src_w[0]))
    else $error("detected edge not shown in source");
  src_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R15]
    (wr_go && avs_address_i == EIP_OFS_SRC && avs_writedata_i[31] && q.edge_f[0]) |=> q.edge_f[0])
    else $error("source bit cleared by a write of one");
  mask_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R19]
    (wr_go && avs_address_i == EIP_OFS_MSK0 && avs_byteenable_i[3] && avs_writedata_i[31]) |=> q.mask[0][0])
    else $error("mask not set by a write of one");
  mask_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R20]
    (q.mask[1][0] && !(wr_go && avs_address_i == EIP_OFS_MCLR1)) |=> q.mask[1][0])
    else $error("mask removed without a clear write");
  mask_clr_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R21]
    (wr_go && avs_address_i == EIP_OFS_MCLR0 && avs_byteenable_i[3] && avs_writedata_i[31]) |=> !q.mask[0][0])
    else $error("mask not removed by clear write");
  req_prio_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R11]
    cpu_req_o[0] |-> cpu_level_o[3:0] != 4'h0)
    else $error("request presented with priority zero");
  req_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R24]
    (cpu_req_o[0] && !cpu_accept_i[0]) |=> (cpu_req_o[0] && $stable(cpu_pin_o[2:0])))
    else $error("presented request dropped before acceptance");
  sense_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R09]
    (wr_go && avs_address_i == EIP_OFS_SENSE && avs_byteenable_i[3] && !q.sense[0][1] &&
     !avs_writedata_i[31] && q.edge_f[0]) |=> q.edge_f[0])
    else $error("edge request lost on a switch between edges");
  level_edge_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R08]
    (wr_go && avs_address_i == EIP_OFS_SENSE && avs_byteenable_i[3] && q.sense[0][1] &&
     !avs_writedata_i[31]) |=> !q.edge_f[0])
    else $error("held request kept after switch to edge sense");
  src_arm_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R15]
    (wr_go && avs_address_i == EIP_OFS_SRC && !avs_writedata_i[31] && !q.rd1[0] &&
     q.edge_f[0]) |=> q.edge_f[0])
    else $error("source bit cleared without a prior read of one");
  level_accept_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R16]
    (cpu_req_o[0] && cpu_accept_i[0] && cpu_pin_o[2:0] == 3'h0 && q.sense[0][1]) |=> !src_w[0])
    else $error("level source still shown after acceptance");

endmodule
